// File: offdelay_retentive_timer_counter.sv
// off-delay timer, retentive timer and counter element with apb register access
`timescale 1ns/1ps
`include "timer_counter_map.svh"

// Notes on behaviour
// - off-delay timing starts only when its rung goes from true to false
// - off-delay counts one completed timebase interval per scan while rung false until elapsed reaches target
// - off-delay elapsed cleared whenever rung becomes true
// - off-delay done set while rung true, cleared when false and elapsed reached target
// - off-delay timing set while rung false and below target; clears otherwise
// - off-delay flags and elapsed held while not in run or test
// - off-delay resume with rung true: timing clear, done set, active set, elapsed zero
// - off-delay resume with rung false: flags clear, elapsed loaded with target
// - off-delay timer ignores an inactive master control zone
// - retentive elapsed kept over rung false, program, fault, power loss; here reset clears elapsed and flags to zero
// - retentive done set at or above target, held until clear
// - retentive timing set while rung true below target; active follows rung
// - retentive flags and elapsed held while not in run or test
// - retentive resume with rung true continues counting from held value
// - retentive resume with rung false clears timing and active only
// - counter has control, target and running count words
// - counter done at or above target; counts rung rising edges since clear
// - counter target and count are signed sixteen-bit values
// - counter control word bit layout fifteen down to ten
// - counter wrap flags set on passing positive or negative limit
// - timebase selectable between ten milliseconds and one second
// - negative timer target or elapsed raises a runtime error
// - timer has control, target and elapsed words
module offdelay_retentive_timer_counter #(
  parameter int FAST_TICK_CYCLES = `TB_FAST_US * `CLK_MHZ,
  parameter int SLOW_PER_FAST = `TB_SLOW_US / `TB_FAST_US
) (
  input wire logic clk, // 40 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [1:0] modeIn, // controller operating mode
  input wire logic scanStrobe, // one-cycle rung evaluation pulse
  input wire logic offRung, // off-delay rung condition
  input wire logic retRung, // retentive rung condition
  input wire logic retClear, // clear instruction for retentive timer
  input wire logic upRung, // count-up rung condition
  input wire logic downRung, // count-down rung condition
  input wire logic cntClear, // clear instruction for counter
  input wire logic zoneInactive, // master control zone inactive
  output logic offDone, // off-delay done flag
  output logic retDone, // retentive done flag
  output logic cntDone // counter done flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  timer_counter_pkg::word_type offCtrl_q, offTarget_q, offElapsed_q;
  timer_counter_pkg::word_type retCtrl_q, retTarget_q, retElapsed_q;
  timer_counter_pkg::word_type cntCtrl_q, cntTarget_q, cntCount_q;
  logic [1:0] config_q, error_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] fastCnt_q;
  logic [31:0] slowCnt_q;
  logic fastTick, slowTick;
  logic offPend_q, retPend_q;
  logic wasRun_q, resume_q;
  logic runActive, scan;
  logic wrEn, rdSetup, addrHit;
  logic offErr, retErr;

  assign runActive = (modeIn == `MODE_RUN) || (modeIn == `MODE_TEST);
  assign scan = scanStrobe && runActive;
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable;
  assign offErr = offTarget_q[`SIGN_BIT] || offElapsed_q[`SIGN_BIT];
  assign retErr = retTarget_q[`SIGN_BIT] || retElapsed_q[`SIGN_BIT];

  // ----------------------------------------------------------------
  // timebase divider
  // ----------------------------------------------------------------
  assign fastTick = (fastCnt_q == 32'(FAST_TICK_CYCLES - 1));
  assign slowTick = fastTick && (slowCnt_q == 32'(SLOW_PER_FAST - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fastCnt_q <= `BUS_ZERO;
      slowCnt_q <= `BUS_ZERO;
    end else if (fastTick) begin
      fastCnt_q <= `BUS_ZERO;
      slowCnt_q <= slowTick ? `BUS_ZERO : slowCnt_q + 32'h0000_0001;
    end else begin
      fastCnt_q <= fastCnt_q + 32'h0000_0001;
    end
  end

  // completed intervals wait for the next rung evaluation
  always_ff @(posedge clk) begin
    if (!rst_n || !runActive) begin
      offPend_q <= 1'b0;
      retPend_q <= 1'b0;
    end else begin
      if (config_q[`CFG_OFF_SLOW_BIT] ? slowTick : fastTick) begin
        offPend_q <= 1'b1;
      end else if (scan) begin
        offPend_q <= 1'b0;
      end
      if (config_q[`CFG_RET_SLOW_BIT] ? slowTick : fastTick) begin
        retPend_q <= 1'b1;
      end else if (scan) begin
        retPend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wasRun_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      wasRun_q <= runActive;
      if (runActive && !wasRun_q) begin
        resume_q <= 1'b1;
      end else if (scan) begin
        resume_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // off-delay timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offCtrl_q <= `WORD_ZERO;
      offElapsed_q <= `WORD_ZERO;
      offTarget_q <= `WORD_ZERO;
    end else begin
      if (wrEn && paddr == `OFF_TARGET_ADDR) begin
        offTarget_q <= pwdata[15:0];
      end
      if (wrEn && paddr == `OFF_ELAPSED_ADDR) begin
        offElapsed_q <= pwdata[15:0];
      end else if (scan && resume_q) begin
        if (offRung) begin
          offCtrl_q[`TIMING_BIT] <= 1'b0;
          offCtrl_q[`DONE_BIT] <= 1'b1;
          offCtrl_q[`RUNG_ACTIVE_BIT] <= 1'b1;
          offElapsed_q <= `WORD_ZERO;
        end else begin
          offCtrl_q[`TIMING_BIT] <= 1'b0;
          offCtrl_q[`DONE_BIT] <= 1'b0;
          offCtrl_q[`RUNG_ACTIVE_BIT] <= 1'b0;
          offElapsed_q <= offTarget_q;
        end
      end else if (scan) begin
        // runs regardless of zoneInactive
        offCtrl_q[`RUNG_ACTIVE_BIT] <= offRung;
        if (offRung) begin
          offElapsed_q <= `WORD_ZERO;
          offCtrl_q[`DONE_BIT] <= 1'b1;
          offCtrl_q[`TIMING_BIT] <= 1'b0;
        end else if (offCtrl_q[`DONE_BIT] && !offErr) begin
          // done only set by a true rung, so timing needs a true-to-false edge
          if (offElapsed_q >= offTarget_q) begin
            offCtrl_q[`DONE_BIT] <= 1'b0;
            offCtrl_q[`TIMING_BIT] <= 1'b0;
          end else if (offPend_q && offElapsed_q + `WORD_ONE >= offTarget_q) begin
            offElapsed_q <= offElapsed_q + `WORD_ONE;
            offCtrl_q[`DONE_BIT] <= 1'b0;
            offCtrl_q[`TIMING_BIT] <= 1'b0;
          end else begin
            if (offPend_q) begin
              offElapsed_q <= offElapsed_q + `WORD_ONE;
            end
            offCtrl_q[`TIMING_BIT] <= 1'b1;
          end
        end
      end
      // outside run or test only apb writes change target and elapsed
    end
  end

  // ----------------------------------------------------------------
  // retentive timer
  // ----------------------------------------------------------------
  logic retRungEff;
  timer_counter_pkg::word_type retNext;

  assign retRungEff = retRung && !zoneInactive;
  assign retNext = (retPend_q && !retCtrl_q[`DONE_BIT]) ? retElapsed_q + `WORD_ONE : retElapsed_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retCtrl_q <= `WORD_ZERO;
      retElapsed_q <= `WORD_ZERO;
      retTarget_q <= `WORD_ZERO;
    end else begin
      if (wrEn && paddr == `RET_TARGET_ADDR) begin
        retTarget_q <= pwdata[15:0];
      end
      if (retClear) begin
        retCtrl_q <= `WORD_ZERO;
        retElapsed_q <= `WORD_ZERO;
      end else if (wrEn && paddr == `RET_ELAPSED_ADDR) begin
        retElapsed_q <= pwdata[15:0];
      end else if (scan) begin
        // resume with rung true or false falls into the normal scan
        retCtrl_q[`RUNG_ACTIVE_BIT] <= retRungEff;
        if (retRungEff && !retErr) begin
          retElapsed_q <= retNext;
          if (retNext >= retTarget_q) begin
            retCtrl_q[`DONE_BIT] <= 1'b1;
            retCtrl_q[`TIMING_BIT] <= 1'b0;
          end else begin
            retCtrl_q[`TIMING_BIT] <= 1'b1;
          end
        end else begin
          // elapsed kept when the rung is false
          retCtrl_q[`TIMING_BIT] <= 1'b0;
          if (!retErr && retElapsed_q >= retTarget_q) begin
            retCtrl_q[`DONE_BIT] <= 1'b1;
          end
        end
      end
      // program and fault hold flags and elapsed apart from retClear and apb writes; reset clears them to zero
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic upEdge, downEdge;
  timer_counter_pkg::word_type cntNext;

  assign upEdge = upRung && !zoneInactive && !cntCtrl_q[`UP_COUNT_BIT];
  assign downEdge = downRung && !zoneInactive && !cntCtrl_q[`DOWN_COUNT_BIT];
  // two's complement add, wraps between the limits
  assign cntNext = cntCount_q + (upEdge ? `WORD_ONE : `WORD_ZERO) - (downEdge ? `WORD_ONE : `WORD_ZERO);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cntCtrl_q <= `WORD_ZERO;
      cntCount_q <= `WORD_ZERO;
      cntTarget_q <= `WORD_ZERO;
    end else begin
      if (wrEn && paddr == `CNT_TARGET_ADDR) begin
        cntTarget_q <= pwdata[15:0];
      end
      if (cntClear) begin
        cntCtrl_q <= `WORD_ZERO;
        cntCount_q <= `WORD_ZERO;
      end else if (wrEn && paddr == `CNT_COUNT_ADDR) begin
        cntCount_q <= pwdata[15:0];
      end else if (scan) begin
        cntCtrl_q[`UP_COUNT_BIT] <= upRung && !zoneInactive;
        cntCtrl_q[`DOWN_COUNT_BIT] <= downRung && !zoneInactive;
        cntCount_q <= cntNext;
        cntCtrl_q[`DONE_BIT] <= $signed(cntNext) >= $signed(cntTarget_q);
        if (upEdge && !downEdge && cntCount_q == `POS_LIMIT) begin
          cntCtrl_q[`HIGH_WRAP_BIT] <= 1'b1;
        end else if (downEdge && !upEdge && cntCount_q == `NEG_LIMIT) begin
          cntCtrl_q[`HIGH_WRAP_BIT] <= 1'b0;
        end
        if (downEdge && !upEdge && cntCount_q == `NEG_LIMIT) begin
          cntCtrl_q[`LOW_WRAP_BIT] <= 1'b1;
        end else if (upEdge && !downEdge && cntCount_q == `POS_LIMIT) begin
          cntCtrl_q[`LOW_WRAP_BIT] <= 1'b0;
        end
      end
      cntCtrl_q[`COUNT_LOAD_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // config and error registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_q <= 2'h0;
    end else if (wrEn && paddr == `CONFIG_ADDR) begin
      config_q <= pwdata[1:0];
    end
  end

  // sticky error bits, write one to clear, a new error wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      error_q <= 2'h0;
    end else begin
      error_q[`ERR_OFF_BIT] <= (scan && offErr) ||
        (error_q[`ERR_OFF_BIT] && !(wrEn && paddr == `ERROR_ADDR && pwdata[`ERR_OFF_BIT]));
      error_q[`ERR_RET_BIT] <= (scan && retErr) ||
        (error_q[`ERR_RET_BIT] && !(wrEn && paddr == `ERROR_ADDR && pwdata[`ERR_RET_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // apb read path, data captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    addrHit = 1'b1;
    case (paddr)
      `OFF_CTRL_ADDR, `OFF_TARGET_ADDR, `OFF_ELAPSED_ADDR: addrHit = 1'b1;
      `RET_CTRL_ADDR, `RET_TARGET_ADDR, `RET_ELAPSED_ADDR: addrHit = 1'b1;
      `CNT_CTRL_ADDR, `CNT_TARGET_ADDR, `CNT_COUNT_ADDR: addrHit = 1'b1;
      `CONFIG_ADDR, `ERROR_ADDR: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= `BUS_ZERO;
      pslverr_q <= 1'b0;
    end else if (rdSetup) begin
      pslverr_q <= !addrHit;
      case (paddr)
        `OFF_CTRL_ADDR: prdata_q <= {16'h0000, offCtrl_q};
        `OFF_TARGET_ADDR: prdata_q <= {16'h0000, offTarget_q};
        `OFF_ELAPSED_ADDR: prdata_q <= {16'h0000, offElapsed_q};
        `RET_CTRL_ADDR: prdata_q <= {16'h0000, retCtrl_q};
        `RET_TARGET_ADDR: prdata_q <= {16'h0000, retTarget_q};
        `RET_ELAPSED_ADDR: prdata_q <= {16'h0000, retElapsed_q};
        `CNT_CTRL_ADDR: prdata_q <= {16'h0000, cntCtrl_q};
        `CNT_TARGET_ADDR: prdata_q <= {16'h0000, cntTarget_q};
        `CNT_COUNT_ADDR: prdata_q <= {16'h0000, cntCount_q};
        `CONFIG_ADDR: prdata_q <= {30'h0000_0000, config_q};
        `ERROR_ADDR: prdata_q <= {30'h0000_0000, error_q};
        default: prdata_q <= `BUS_ZERO;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;
  assign offDone = offCtrl_q[`DONE_BIT];
  assign retDone = retCtrl_q[`DONE_BIT];
  assign cntDone = cntCtrl_q[`DONE_BIT];

endmodule : offdelay_retentive_timer_counter

// File: timer_counter_map.svh
// register map, bit positions and timing constants of the timer and counter block
`ifndef TIMER_COUNTER_MAP_SVH
`define TIMER_COUNTER_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL_ADDR 12'h000
`define OFF_TARGET_ADDR 12'h004
`define OFF_ELAPSED_ADDR 12'h008
`define RET_CTRL_ADDR 12'h00c
`define RET_TARGET_ADDR 12'h010
`define RET_ELAPSED_ADDR 12'h014
`define CNT_CTRL_ADDR 12'h018
`define CNT_TARGET_ADDR 12'h01c
`define CNT_COUNT_ADDR 12'h020
`define CONFIG_ADDR 12'h024
`define ERROR_ADDR 12'h028

// ----------------------------------------------------------------
// control word bit positions
// ----------------------------------------------------------------
`define RUNG_ACTIVE_BIT 15
`define TIMING_BIT 14
`define DONE_BIT 13
`define UP_COUNT_BIT 15
`define DOWN_COUNT_BIT 14
`define HIGH_WRAP_BIT 12
`define LOW_WRAP_BIT 11
`define COUNT_LOAD_BIT 10
`define SIGN_BIT 15

// ----------------------------------------------------------------
// config and error bits
// ----------------------------------------------------------------
`define CFG_OFF_SLOW_BIT 0
`define CFG_RET_SLOW_BIT 1
`define ERR_OFF_BIT 0
`define ERR_RET_BIT 1

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define POS_LIMIT 16'h7fff
`define NEG_LIMIT 16'h8000
`define BUS_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// operating modes on the mode input
// ----------------------------------------------------------------
`define MODE_PROGRAM 2'h0
`define MODE_RUN 2'h1
`define MODE_TEST 2'h2
`define MODE_FAULT 2'h3

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define CLK_MHZ 40
`define TB_FAST_US 10000
`define TB_SLOW_US 1000000

`endif

// File: timer_counter_pkg.sv
// shared types of the timer and counter block
package timer_counter_pkg;
  typedef logic [15:0] word_type;
  typedef logic [1:0] mode_type;
endpackage : timer_counter_pkg

// File: offdelay_retentive_timer_counter_checker.sv
// concurrent checks on the ports of the timer and counter block
`timescale 1ns/1ps
`include "timer_counter_map.svh"
module offdelay_retentive_timer_counter_checker (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [11:0] paddr, // apb address
  input wire logic pslverr, // apb error
  input wire logic [1:0] modeIn, // operating mode
  input wire logic scanStrobe, // rung evaluation
  input wire logic offRung, // off-delay rung
  input wire logic retClear, // retentive clear
  input wire logic cntClear, // counter clear
  input wire logic offDone, // off-delay done
  input wire logic retDone, // retentive done
  input wire logic cntDone // counter done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_off_rung_done: assert property (scanStrobe && offRung && (modeIn == `MODE_RUN || modeIn == `MODE_TEST)
    |=> offDone) else $error("off-delay done not set by true rung");
  a_off_done_fall: assert property ($fell(offDone) |-> $past(scanStrobe) && !$past(offRung))
    else $error("off-delay done cleared without false rung scan");
  a_ret_done_hold: assert property (retDone && !retClear |=> retDone)
    else $error("retentive done dropped without clear");
  a_ret_clear_zero: assert property (retClear |=> !retDone)
    else $error("retentive clear left done set");
  a_cnt_clear_zero: assert property (cntClear |=> !cntDone)
    else $error("counter clear left done set");
  a_idle_mode_hold: assert property (scanStrobe && (modeIn == `MODE_PROGRAM || modeIn == `MODE_FAULT)
    && !retClear && !cntClear |=> $stable({offDone, retDone, cntDone})) else $error("flags moved outside run");
  a_done_scan_only: assert property (!$past(scanStrobe) && !$past(retClear) |-> $stable({offDone, retDone}))
    else $error("timer done moved between scans");
  a_cnt_done_scan: assert property ($changed(cntDone) |-> $past(scanStrobe) || $past(cntClear))
    else $error("counter done moved between scans");
  a_unmapped_err: assert property (psel && penable && paddr > `ERROR_ADDR |-> pslverr)
    else $error("no error on unmapped address");
endmodule : offdelay_retentive_timer_counter_checker

bind offdelay_retentive_timer_counter offdelay_retentive_timer_counter_checker chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .modeIn(modeIn), .scanStrobe(scanStrobe),
  .offRung(offRung), .retClear(retClear), .cntClear(cntClear), .offDone(offDone), .retDone(retDone),
  .cntDone(cntDone));

// File: offdelay_retentive_timer_counter_tb_top.sv
// self-checking testbench of the timer and counter block
`timescale 1ns/1ps
`include "timer_counter_map.svh"
module offdelay_retentive_timer_counter_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [1:0] modeIn = `MODE_RUN;
  logic scanStrobe = 0, offRung = 0, retRung = 0, retClear = 0, upRung = 0, downRung = 0, cntClear = 0;
  logic zoneInactive = 0, offDone, retDone, cntDone;
  int errTotal = 0, testsRun = 0;

  offdelay_retentive_timer_counter #(.FAST_TICK_CYCLES(10), .SLOW_PER_FAST(3)) DUT (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modeIn(modeIn), .scanStrobe(scanStrobe), .offRung(offRung),
    .retRung(retRung), .retClear(retClear), .upRung(upRung), .downRung(downRung), .cntClear(cntClear),
    .zoneInactive(zoneInactive), .offDone(offDone), .retDone(retDone), .cntDone(cntDone));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk);
    penable <= 1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, {16'h0000, d}, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0000_0000, r, e);
    check(r, {16'h0000, exp});
    check({31'h0, e}, 0);
  endtask : rd

  task automatic scan(input logic o, input logic r, input logic u, input logic d);
    @(posedge clk);
    offRung <= o; retRung <= r; upRung <= u; downRung <= d; scanStrobe <= 1;
    @(posedge clk);
    scanStrobe <= 0;
    repeat (12) @(posedge clk);
  endtask : scan

  task automatic pulse(input logic ret);
    @(posedge clk);
    if (ret) retClear <= 1; else cntClear <= 1;
    @(posedge clk);
    retClear <= 0; cntClear <= 0;
    @(posedge clk);
  endtask : pulse

  task automatic test_bus;
    logic [31:0] r;
    logic e;
    rd(`OFF_CTRL_ADDR, 16'h0000);
    wr(`OFF_CTRL_ADDR, 16'hffff);
    rd(`OFF_CTRL_ADDR, 16'h0000);
    apb(0, 12'h02c, 32'h0000_0000, r, e);
    check({31'h0, e}, 1);
    $display("test bus done");
  endtask : test_bus

  // the off-delay timer never gets a clear pulse
  task automatic test_off;
    zoneInactive <= 1;
    wr(`OFF_TARGET_ADDR, 16'h0002);
    scan(1, 0, 0, 0);
    rd(`OFF_CTRL_ADDR, 16'ha000);
    scan(0, 0, 0, 0);
    rd(`OFF_CTRL_ADDR, 16'h6000);
    rd(`OFF_ELAPSED_ADDR, 16'h0001);
    scan(0, 0, 0, 0);
    check({31'h0, offDone}, 0);
    rd(`OFF_ELAPSED_ADDR, 16'h0002);
    scan(1, 0, 0, 0);
    rd(`OFF_ELAPSED_ADDR, 16'h0000);
    wr(`OFF_TARGET_ADDR, 16'h0005);
    scan(0, 0, 0, 0);
    modeIn <= `MODE_PROGRAM;
    scan(0, 0, 0, 0);
    rd(`OFF_CTRL_ADDR, 16'h6000);
    rd(`OFF_ELAPSED_ADDR, 16'h0001);
    modeIn <= `MODE_TEST;
    scan(0, 0, 0, 0);
    rd(`OFF_CTRL_ADDR, 16'h0000);
    rd(`OFF_ELAPSED_ADDR, 16'h0005);
    scan(0, 0, 0, 0);
    modeIn <= `MODE_PROGRAM;
    scan(0, 0, 0, 0);
    modeIn <= `MODE_RUN;
    scan(1, 0, 0, 0);
    rd(`OFF_CTRL_ADDR, 16'ha000);
    rd(`OFF_ELAPSED_ADDR, 16'h0000);
    zoneInactive <= 0;
    $display("test off-delay done");
  endtask : test_off

  task automatic test_ret;
    wr(`RET_TARGET_ADDR, 16'h0002);
    // earlier scans met elapsed zero at target zero and set done
    pulse(1);
    scan(1, 1, 0, 0);
    rd(`RET_CTRL_ADDR, 16'hc000);
    modeIn <= `MODE_FAULT;
    scan(1, 0, 0, 0);
    rd(`RET_CTRL_ADDR, 16'hc000);
    modeIn <= `MODE_RUN;
    scan(1, 0, 0, 0);
    rd(`RET_CTRL_ADDR, 16'h0000);
    rd(`RET_ELAPSED_ADDR, 16'h0001);
    scan(1, 1, 0, 0);
    rd(`RET_CTRL_ADDR, 16'ha000);
    scan(1, 0, 0, 0);
    check({31'h0, retDone}, 1);
    rd(`RET_ELAPSED_ADDR, 16'h0002);
    pulse(1);
    rd(`RET_CTRL_ADDR, 16'h0000);
    rd(`RET_ELAPSED_ADDR, 16'h0000);
    $display("test retentive done");
  endtask : test_ret

  task automatic test_cfg;
    logic [31:0] r;
    logic e;
    wr(`RET_TARGET_ADDR, 16'h8000);
    scan(1, 0, 0, 0);
    rd(`ERROR_ADDR, 16'h0002);
    wr(`ERROR_ADDR, 16'h0002);
    rd(`ERROR_ADDR, 16'h0000);
    wr(`RET_TARGET_ADDR, 16'h0010);
    wr(`CONFIG_ADDR, 16'h0002);
    rd(`CONFIG_ADDR, 16'h0002);
    pulse(1);
    // four scans 14 cycles apart see at most three slow ticks
    repeat (4) scan(1, 1, 0, 0);
    apb(0, `RET_ELAPSED_ADDR, 32'h0000_0000, r, e);
    check({31'h0, r[15:0] < 16'h0004}, 1);
    check({31'h0, r[15:0] != 16'h0000}, 1);
    $display("test config done");
  endtask : test_cfg

  task automatic test_cnt;
    wr(`CNT_TARGET_ADDR, 16'h7fff);
    wr(`CNT_COUNT_ADDR, 16'h7fff);
    scan(1, 0, 1, 0);
    rd(`CNT_COUNT_ADDR, 16'h8000);
    rd(`CNT_CTRL_ADDR, 16'h9000);
    scan(1, 0, 0, 1);
    rd(`CNT_CTRL_ADDR, 16'h6800);
    check({31'h0, cntDone}, 1);
    pulse(0);
    rd(`CNT_CTRL_ADDR, 16'h0000);
    wr(`CNT_TARGET_ADDR, 16'h8000);
    wr(`CNT_COUNT_ADDR, 16'h8000);
    scan(1, 0, 0, 0);
    scan(1, 0, 0, 1);
    rd(`CNT_COUNT_ADDR, 16'h7fff);
    rd(`CNT_CTRL_ADDR, 16'h6800);
    pulse(0);
    rd(`CNT_CTRL_ADDR, 16'h0000);
    rd(`CNT_COUNT_ADDR, 16'h0000);
    $display("test counter done");
  endtask : test_cnt

  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : printVerdict

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    test_bus();
    test_off();
    test_ret();
    test_cfg();
    test_cnt();
    printVerdict();
  end

  initial begin
    repeat (8000) @(posedge clk);
    errTotal++;
    printVerdict();
  end
endmodule : offdelay_retentive_timer_counter_tb_top
